/* File: common/rps_params.svh */
// constants of the rgb pattern command sequencer
//
// Function
// - no averaging: 122 Hz sampling, 8.2 ms updates
// - averaging: 244 Hz, 64 samples, 262 ms
// - speed field 00..11: fastest, fast, medium, slow
// - first byte: red, green, execution time high
// - second byte: execution low, blue, fade
// - code to percent: linear or logarithmic table
// - execution time 197 to 3146 ms, even steps
// - fade time 0 to 3539 ms by code
// - command bytes read/write, reset to zero
// - curve bit: clear linear, set logarithmic
// - start bit runs from slot 0; clear stops
// - loop bit repeats; clear runs pattern once
`ifndef RPS_PARAMS_SVH
`define RPS_PARAMS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define CLK_HZ         10000000
`define MS_PER_S       1000
`define ADC_SLOW_HZ    122
`define ADC_FAST_HZ    244
`define AVG_LAST       6'h3F
`define AVG_SHIFT      6
`define CET_MIN_MS     197
`define CET_MAX_MS     3146
`define CET_STEPS      15
`define TT_MAX_MS      3539
`define TT_RATIO       64
`define RAMP_STEPS     7'h64
`define RAMP_STEPS_S   16'sh0064
`define PWM_LAST       7'h63
`define TMR_W          25

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_PAT_CTRL  8'h11
`define ADDR_MAX_CUR   8'h12
`define ADDR_AUDIO     8'h2B
`define ADDR_ADC_RES   8'h2C
`define ADDR_STATUS    8'h2D
`define ADDR_CMD_HI    4'h5

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CTRL_LOG       0
`define CTRL_LOOP      1
`define CTRL_START     2
`define CTRL_MASK      8'h0F
`define MAX_CUR_MASK   8'h3F
`define AUDIO_MASK     8'h1F
`define AUD_AVG        4
`define RST_BYTE       8'h00
`define LAST_SLOT      3'h7
`define RED_HI         15
`define GRN_HI         12
`define CET_A_HI       9
`define CET_B_HI       7
`define BLU_HI         5
`define FADE_HI        2

`endif

/* File: common/rps_pkg.sv */
// types of the rgb pattern command sequencer
package rps_pkg;

  typedef enum logic [1:0] {
    RPS_IDLE  = 2'b00,
    RPS_FETCH = 2'b01,
    RPS_RUN   = 2'b10,
    RPS_DONE  = 2'b11
  } rps_state_t;

  typedef logic [6:0] rps_duty_t;

endpackage

/* File: common/rps_cmd_if.sv */
// link between sequencer and command store
`timescale 1ns/1ps
interface rps_cmd_if;
  logic        wr_en;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [2:0]  slot;
  logic [15:0] slot_word;

  modport store (input wr_en, input addr, input wdata, input slot, output rdata, output slot_word);
  modport user  (output wr_en, output addr, output wdata, output slot, input rdata, input slot_word);
endinterface

/* File: design/rps_cmd_mem.sv */
// command slot store, sixteen bytes with registered reads
`timescale 1ns/1ps
module rps_cmd_mem
  import rps_pkg::*;
(
  input wire logic    clk,
  input wire logic    rst_n,
  rps_cmd_if.store    bus
);
`include "rps_params.svh"

  logic [7:0] byte_reg [0:15];

  for (genvar i = 0; i < 16; i++) begin : g_byte
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        byte_reg[i] <= `RST_BYTE;
      end else if (bus.wr_en && bus.addr == 4'(i)) begin
        byte_reg[i] <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus.rdata     <= `RST_BYTE;
      bus.slot_word <= {`RST_BYTE, `RST_BYTE};
    end else begin
      bus.rdata     <= byte_reg[bus.addr];
      bus.slot_word <= {byte_reg[{bus.slot, 1'b0}], byte_reg[{bus.slot, 1'b1}]};
    end
  end

endmodule

/* File: design/rps_pwm.sv */
// three channel pwm, period of one hundred clocks
`timescale 1ns/1ps
module rps_pwm
  import rps_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [20:0] duty,
  output logic     [2:0]  pwm_out
);
`include "rps_params.svh"

  logic [6:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 7'h00;
    end else if (cnt_reg == `PWM_LAST) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
    end
  end

  for (genvar c = 0; c < 3; c++) begin : g_out
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pwm_out[c] <= 1'b0;
      end else begin
        pwm_out[c] <= cnt_reg < duty[c*7 +: 7];
      end
    end
  end

endmodule

/* File: design/rps_top.sv */
// rgb pattern command sequencer with adc result and audio response control
`timescale 1ns/1ps
`include "rps_params.svh"
module rps_top
  import rps_pkg::*;
#(
  parameter int ADC_SLOW_CYC  = `CLK_HZ / `ADC_SLOW_HZ,
  parameter int ADC_FAST_CYC  = `CLK_HZ / `ADC_FAST_HZ,
  parameter int CET_MIN_CYC   = `CET_MIN_MS * (`CLK_HZ / `MS_PER_S),
  parameter int CET_STEP_CYC  = (`CET_MAX_MS - `CET_MIN_MS) * (`CLK_HZ / `MS_PER_S) / `CET_STEPS,
  parameter int RAMP_BASE_CYC = `TT_MAX_MS * (`CLK_HZ / `MS_PER_S) / (`TT_RATIO * 100)
)
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  output logic     [7:0]  reg_rdata,
  output logic            reg_rvalid,
  input wire logic [7:0]  adc_data,
  input wire logic        adc_done,
  output logic            adc_start,
  output logic     [2:0]  pwm_out,
  output logic     [5:0]  current_scale,
  output logic     [1:0]  audio_speed,
  output logic     [1:0]  filter_mode
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_cmd_addr(input logic [7:0] a);
    return a[7:4] == `ADDR_CMD_HI;
  endfunction

  function automatic rps_duty_t intensity_pct(input logic [2:0] code, input logic log_mode);
    rps_duty_t pct;
    pct = 7'h00;
    if (log_mode) begin
      case (code)
        3'h1:    pct = 7'h01;
        3'h2:    pct = 7'h02;
        3'h3:    pct = 7'h04;
        3'h4:    pct = 7'h0A;
        3'h5:    pct = 7'h15;
        3'h6:    pct = 7'h2E;
        3'h7:    pct = 7'h64;
        default: pct = 7'h00;
      endcase
    end else begin
      case (code)
        3'h1:    pct = 7'h07;
        3'h2:    pct = 7'h0E;
        3'h3:    pct = 7'h15;
        3'h4:    pct = 7'h20;
        3'h5:    pct = 7'h2E;
        3'h6:    pct = 7'h47;
        3'h7:    pct = 7'h64;
        default: pct = 7'h00;
      endcase
    end
    return pct;
  endfunction

  function automatic logic [`TMR_W-1:0] ramp_period(input logic [2:0] fade);
    return `TMR_W'(RAMP_BASE_CYC) << (fade - 3'h1);
  endfunction

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] max_cur_reg;
  logic [7:0] audio_reg;
  logic [7:0] adc_res_reg;
  logic [7:0] status_byte;
  logic [7:0] rd_local_reg;
  logic       rd_pend_reg;
  logic       rd_cmd_reg;
  logic       start_pulse;
  logic       ctrl_wr;

  rps_cmd_if cmd ();

  assign ctrl_wr     = reg_wr && reg_addr == `ADDR_PAT_CTRL;
  assign start_pulse = ctrl_wr && reg_wdata[`CTRL_START] && !ctrl_reg[`CTRL_START];

  assign cmd.wr_en = reg_wr && is_cmd_addr(reg_addr);
  assign cmd.addr  = reg_addr[3:0];
  assign cmd.wdata = reg_wdata;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= `RST_BYTE;
    end else if (ctrl_wr) begin
      ctrl_reg <= reg_wdata & `CTRL_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      max_cur_reg <= `RST_BYTE;
    end else if (reg_wr && reg_addr == `ADDR_MAX_CUR) begin
      max_cur_reg <= reg_wdata & `MAX_CUR_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      audio_reg <= `RST_BYTE;
    end else if (reg_wr && reg_addr == `ADDR_AUDIO) begin
      audio_reg <= reg_wdata & `AUDIO_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_pend_reg  <= 1'b0;
      rd_cmd_reg   <= 1'b0;
      rd_local_reg <= `RST_BYTE;
    end else begin
      rd_pend_reg <= reg_rd;
      rd_cmd_reg  <= is_cmd_addr(reg_addr);
      case (reg_addr)
        `ADDR_PAT_CTRL: rd_local_reg <= ctrl_reg;
        `ADDR_MAX_CUR:  rd_local_reg <= max_cur_reg;
        `ADDR_AUDIO:    rd_local_reg <= audio_reg;
        `ADDR_ADC_RES:  rd_local_reg <= adc_res_reg;
        `ADDR_STATUS:   rd_local_reg <= status_byte;
        default:        rd_local_reg <= `RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rvalid <= 1'b0;
      reg_rdata  <= `RST_BYTE;
    end else begin
      reg_rvalid <= rd_pend_reg;
      if (rd_pend_reg) begin
        reg_rdata <= rd_cmd_reg ? cmd.rdata : rd_local_reg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      current_scale <= 6'h00;
      audio_speed   <= 2'h0;
      filter_mode   <= 2'h0;
    end else begin
      current_scale <= max_cur_reg[5:0];
      audio_speed   <= audio_reg[1:0];
      filter_mode   <= audio_reg[3:2];
    end
  end

  // ----------------------------------------------------------------
  // adc sampling and averaging
  // ----------------------------------------------------------------
  logic [`TMR_W-1:0] adc_cnt_reg;
  logic [13:0]       acc_reg;
  logic [5:0]        avg_cnt_reg;
  logic              avg_on;

  assign avg_on = audio_reg[`AUD_AVG];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      adc_cnt_reg <= '0;
      adc_start   <= 1'b0;
    end else if (adc_cnt_reg == '0) begin
      adc_cnt_reg <= avg_on ? `TMR_W'(ADC_FAST_CYC - 1) : `TMR_W'(ADC_SLOW_CYC - 1);
      adc_start   <= 1'b1;
    end else begin
      adc_cnt_reg <= adc_cnt_reg - `TMR_W'(1);
      adc_start   <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_reg     <= 14'h0000;
      avg_cnt_reg <= 6'h00;
      adc_res_reg <= `RST_BYTE;
    end else if (!avg_on) begin
      acc_reg     <= 14'h0000;
      avg_cnt_reg <= 6'h00;
      if (adc_done) begin
        adc_res_reg <= adc_data;
      end
    end else if (adc_done) begin
      avg_cnt_reg <= avg_cnt_reg + 6'h01;
      if (avg_cnt_reg == `AVG_LAST) begin
        adc_res_reg <= 8'((acc_reg + {6'h00, adc_data}) >> `AVG_SHIFT);
        acc_reg     <= 14'h0000;
      end else begin
        acc_reg <= acc_reg + {6'h00, adc_data};
      end
    end
  end

  // ----------------------------------------------------------------
  // pattern sequencer
  // ----------------------------------------------------------------
  rps_state_t        state_reg;
  logic [2:0]        slot_reg;
  logic              fetch_wait_reg;
  logic [`TMR_W-1:0] cet_cnt_reg;
  logic [`TMR_W-1:0] ramp_cnt_reg;
  logic [`TMR_W-1:0] ramp_per_reg;
  logic [6:0]        phase_reg;
  logic [20:0]       start_duty_reg;
  logic [20:0]       tgt_duty_reg;
  logic [20:0]       duty_all;
  logic [15:0]       word;
  logic [3:0]        cet_code;
  logic [2:0]        fade_duration;
  logic              log_mode;

  assign cmd.slot      = slot_reg;
  assign word          = cmd.slot_word;
  assign cet_code      = {word[`CET_A_HI -: 2], word[`CET_B_HI -: 2]};
  assign fade_duration = word[`FADE_HI -: 3];
  assign log_mode      = ctrl_reg[`CTRL_LOG];
  assign status_byte   = {3'h0, state_reg == RPS_DONE, state_reg != RPS_IDLE, slot_reg};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg      <= RPS_IDLE;
      slot_reg       <= 3'h0;
      fetch_wait_reg <= 1'b0;
      cet_cnt_reg    <= '0;
      ramp_cnt_reg   <= '0;
      ramp_per_reg   <= '0;
      phase_reg      <= 7'h00;
      start_duty_reg <= 21'h000000;
      tgt_duty_reg   <= 21'h000000;
    end else if (!ctrl_reg[`CTRL_START] && !start_pulse) begin
      state_reg      <= RPS_IDLE;
      slot_reg       <= 3'h0;
      start_duty_reg <= 21'h000000;
      tgt_duty_reg   <= 21'h000000;
    end else if (start_pulse) begin
      state_reg      <= RPS_FETCH;
      slot_reg       <= 3'h0;
      fetch_wait_reg <= 1'b1;
    end else begin
      case (state_reg)
        RPS_FETCH: begin
          fetch_wait_reg <= 1'b0;
          if (!fetch_wait_reg) begin
            start_duty_reg <= duty_all;
            tgt_duty_reg   <= {intensity_pct(word[`BLU_HI -: 3], log_mode),
                               intensity_pct(word[`GRN_HI -: 3], log_mode),
                               intensity_pct(word[`RED_HI -: 3], log_mode)};
            cet_cnt_reg    <= `TMR_W'(CET_MIN_CYC - 1) + `TMR_W'(cet_code) * `TMR_W'(CET_STEP_CYC);
            phase_reg      <= (fade_duration == 3'h0) ? `RAMP_STEPS : 7'h00;
            ramp_per_reg   <= ramp_period(fade_duration);
            ramp_cnt_reg   <= ramp_period(fade_duration) - `TMR_W'(1);
            state_reg      <= RPS_RUN;
          end
        end
        RPS_RUN: begin
          if (phase_reg != `RAMP_STEPS) begin
            if (ramp_cnt_reg == '0) begin
              ramp_cnt_reg <= ramp_per_reg - `TMR_W'(1);
              phase_reg    <= phase_reg + 7'h01;
            end else begin
              ramp_cnt_reg <= ramp_cnt_reg - `TMR_W'(1);
            end
          end
          if (cet_cnt_reg == '0) begin
            fetch_wait_reg <= 1'b1;
            if (slot_reg != `LAST_SLOT) begin
              slot_reg  <= slot_reg + 3'h1;
              state_reg <= RPS_FETCH;
            end else if (ctrl_reg[`CTRL_LOOP]) begin
              slot_reg  <= 3'h0;
              state_reg <= RPS_FETCH;
            end else begin
              state_reg <= RPS_DONE;
            end
          end else begin
            cet_cnt_reg <= cet_cnt_reg - `TMR_W'(1);
          end
        end
        RPS_DONE: state_reg <= RPS_DONE;
        default:  state_reg <= RPS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // per channel ramp interpolation
  // ----------------------------------------------------------------
  for (genvar c = 0; c < 3; c++) begin : g_ch
    logic signed [15:0] diff_s;
    logic signed [15:0] step_s;
    logic        [6:0]  duty_ch_reg;

    assign diff_s = $signed({9'h000, tgt_duty_reg[c*7 +: 7]}) - $signed({9'h000, start_duty_reg[c*7 +: 7]});
    assign step_s = 16'(diff_s * $signed({9'h000, phase_reg}) / `RAMP_STEPS_S);

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        duty_ch_reg <= 7'h00;
      end else begin
        duty_ch_reg <= 7'($signed({9'h000, start_duty_reg[c*7 +: 7]}) + step_s);
      end
    end

    assign duty_all[c*7 +: 7] = duty_ch_reg;
  end

  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  rps_cmd_mem u_mem (
    .clk   (clk),
    .rst_n (rst_n),
    .bus   (cmd.store)
  );

  rps_pwm u_pwm (
    .clk     (clk),
    .rst_n   (rst_n),
    .duty    (duty_all),
    .pwm_out (pwm_out)
  );

endmodule

/* File: tb/rps_top_properties.sv */
// port assertions for the rgb pattern command sequencer
`timescale 1ns/1ps
module rps_checker
  import rps_pkg::*;
#(
  parameter int ADC_SLOW_CYC = 20
)
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic [7:0] adc_data,
  input wire logic       adc_done,
  input wire logic       adc_start,
  input wire logic [2:0] pwm_out,
  input wire logic [5:0] current_scale,
  input wire logic [1:0] audio_speed,
  input wire logic [1:0] filter_mode
);
  // cycles since the last sample request
  logic [31:0] gap_reg;
  logic        aud_wr;

  assign aud_wr = reg_wr && reg_addr == 8'h2B;

  always_ff @(posedge clk) begin
    if (!rst_n || adc_start) begin
      gap_reg <= 32'h0;
    end else begin
      gap_reg <= gap_reg + 32'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  rd_latency_a: assert property (reg_rd |-> ##2 reg_rvalid)
    else $error("read answer late");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd, 2))
    else $error("read answer without request");
  rdata_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved between answers");
  speed_write_a: assert property (aud_wr |-> ##2 audio_speed == $past(reg_wdata[1:0], 2))
    else $error("speed field not taken");
  filter_write_a: assert property (aud_wr |-> ##2 filter_mode == $past(reg_wdata[3:2], 2))
    else $error("filter field not taken");
  speed_hold_a: assert property (!aud_wr && !$past(aud_wr) |=> $stable(audio_speed))
    else $error("speed field changed unasked");
  scale_write_a: assert property (reg_wr && reg_addr == 8'h12 |-> ##2 current_scale == $past(reg_wdata[5:0], 2))
    else $error("current scale not taken");
  adc_gap_a: assert property (gap_reg < ADC_SLOW_CYC)
    else $error("sample request overdue");
  audio_rsvd_a: assert property (reg_rvalid && $past(reg_addr, 2) == 8'h2B |-> reg_rdata[7:5] == 3'h0)
    else $error("reserved audio bits set");
  stop_dark_a: assert property (reg_wr && reg_addr == 8'h11 && !reg_wdata[2] |-> ##4 pwm_out == 3'h0)
    else $error("outputs lit after stop");
endmodule

bind rps_top rps_checker #(.ADC_SLOW_CYC(ADC_SLOW_CYC)) u_chk (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .adc_data(adc_data),
  .adc_done(adc_done), .adc_start(adc_start), .pwm_out(pwm_out), .current_scale(current_scale),
  .audio_speed(audio_speed), .filter_mode(filter_mode)
);

/* File: tb/rps_top_test.sv */
// self-checking bench for the rgb pattern command sequencer
`timescale 1ns/1ps
module rps_top_test;
  logic       clk;
  logic       rst_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic [7:0] adc_data;
  logic       adc_done;
  logic       adc_start;
  logic [2:0] pwm_out;
  logic [5:0] current_scale;
  logic [1:0] audio_speed;
  logic [1:0] filter_mode;
  logic [7:0] v;
  int         n_mismatch;
  int         tests_run;
  int         pct[2][8] = '{'{0, 7, 14, 21, 32, 46, 71, 100}, '{0, 1, 2, 4, 10, 21, 46, 100}};

  rps_top #(
    .ADC_SLOW_CYC (20),
    .ADC_FAST_CYC (10),
    .CET_MIN_CYC  (50),
    .CET_STEP_CYC (10),
    .RAMP_BASE_CYC(2)
  ) u_dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .adc_data(adc_data),
    .adc_done(adc_done), .adc_start(adc_start), .pwm_out(pwm_out), .current_scale(current_scale),
    .audio_speed(audio_speed), .filter_mode(filter_mode)
  );

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    cyc(1);
    reg_rd = 1'b1;
    reg_addr = a;
    cyc(1);
    reg_rd = 1'b0;
    for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++) begin
      cyc(1);
    end
    chk(16'(reg_rvalid), 16'h1);
    d = reg_rdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(16'(d), 16'(e));
  endtask

  task automatic adc(input logic [7:0] d);
    cyc(1);
    adc_done = 1'b1;
    adc_data = d;
    cyc(1);
    adc_done = 1'b0;
  endtask

  // sample requests seen over 100 cycles
  task automatic rate(input int e);
    int n;
    n = 0;
    cyc(20);
    repeat (100) begin
      cyc(1);
      if (adc_start === 1'b1) begin
        n++;
      end
    end
    chk(16'(n), 16'(e));
  endtask

  // high cycles of each channel over one pwm period
  task automatic meas(input int er, input int eg, input int eb);
    int c[3] = '{0, 0, 0};
    repeat (100) begin
      cyc(1);
      for (int k = 0; k < 3; k++) begin
        if (pwm_out[k] === 1'b1) begin
          c[k]++;
        end
      end
    end
    chk(16'(c[0]), 16'(er));
    chk(16'(c[1]), 16'(eg));
    chk(16'(c[2]), 16'(eb));
  endtask

  // slot 0 holds 200 cycles, slots 1..7 hold 50
  task automatic run(input int lg, input int lp);
    wr(8'h11, 8'h04 | 8'(lp * 2) | 8'(lg));
    cyc(8);
    meas(pct[lg][7], pct[lg][4], pct[lg][1]);
    cyc(85);
    rc(8'h2D, 8'h08);
    cyc(12);
    rc(8'h2D, 8'h09);
    cyc(360);
    rd(8'h2D, v);
    chk(16'(v[4:3]), lp ? 16'h1 : 16'h3);
    meas(pct[lg][7], lp ? pct[lg][4] : 0, lp ? pct[lg][1] : 0);
    wr(8'h11, 8'h00);
    cyc(4);
    chk(16'(pwm_out), 16'h0);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    adc_data = 8'h00;
    adc_done = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    cyc(16);
    rst_n = 1'b1;
    for (int i = 0; i < 16; i++) begin
      rc(8'h50 + 8'(i), 8'h00);
    end
    rc(8'h2B, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr(8'h50 + 8'(i), 8'hA5 ^ 8'(i * 17));
    end
    for (int i = 0; i < 16; i++) begin
      rc(8'h50 + 8'(i), 8'hA5 ^ 8'(i * 17));
    end
    for (int s = 0; s < 4; s++) begin
      wr(8'h2B, 8'(s * 5));
      cyc(1);
      chk(16'(audio_speed), 16'(s));
      chk(16'(filter_mode), 16'(s));
    end
    wr(8'h2B, 8'hFF);
    rc(8'h2B, 8'h1F);
    wr(8'h2B, 8'h00);
    wr(8'h11, 8'hF0);
    rc(8'h11, 8'h00);
    wr(8'h12, 8'hFF);
    rc(8'h12, 8'h3F);
    chk(16'(current_scale), 16'h3F);
    wr(8'h40, 8'hFF);
    rc(8'h40, 8'h00);
    adc(8'h5A);
    rc(8'h2C, 8'h5A);
    wr(8'h2C, 8'h77);
    rc(8'h2C, 8'h5A);
    rate(5);
    wr(8'h2B, 8'h10);
    for (int k = 0; k < 63; k++) begin
      adc(8'(k));
    end
    rc(8'h2C, 8'h5A);
    adc(8'h3F);
    rc(8'h2C, 8'h1F);
    rate(10);
    for (int i = 0; i < 8; i++) begin
      wr(8'h50 + 8'(2 * i), (i == 0) ? 8'hF3 : (i == 7) ? 8'hE0 : 8'h00);
      wr(8'h51 + 8'(2 * i), (i == 0) ? 8'hC8 : 8'h00);
    end
    run(0, 0);
    run(1, 1);
    wr(8'h51, 8'hCF);
    wr(8'h11, 8'h04);
    cyc(8);
    meas(0, 0, 0);
    wr(8'h11, 8'h00);
    summarize();
  end
endmodule
